// >>> lts_logic_tile.v
`timescale 1ns/1ps
`default_nettype none
`include "lts_defines.vh"

// What this block does
// [R1] four slices, 50 fabric inputs and 23 fabric outputs per tile
// [R2] slices 0-2 have two tables and two registers; slice 3 tables only
// [R3] RAM mode only in slices 0 and 2 of the RAM-capable variant
// [R4] local set/reset acts synchronously or asynchronously, by configuration
// [R5] registers capture on rising edge, falling edge, or act as latch
// [R6] slices 0-2 take 13 routing inputs plus carry-in, give 7 outputs
// [R7] slice 3 takes 10 routing inputs, gives 4 outputs, no carry
// [R8] slice 1 gives RAM write clock, enable, address; data split by slice
// [R9] table results and register outputs are both brought out
// [R10] five-input mux per slice plus six/seven/eight-input wide muxes
// [R11] tile carry-out comes from slice 2; carry-in from neighbour
// [R12] each table holds any 4-input function; two make a 5-input one
// [R13] wider functions chain slices; eight inputs span two tiles
// [R14] ripple slices add, subtract, add/subtract, count up or down, 2 bits
// [R15] up/down counters with async clear or sync preload
// [R16] ripple compare ge, ne, le and multiplier step
// [R17] each ripple slice passes a carry in and out
// [R18] 16x4 single-port RAM from slices 0 and 2, control from slice 1
// [R19] 16x2 pseudo dual port: one read-write slice, one read-only
// [R20] ROM mode in all slices, contents loaded through configuration port
// [R21] RAM writes on write-clock edge with enable; reads are combinational
// [R22] clock enable low holds registers except under set/reset
module lts_logic_tile #(
   parameter RAM_CAPABLE = 1
) (
   input wire clk,
   input wire nrst,
   input wire [31:0] table_in,
   input wire [7:0] multi_purpose_in,
   input wire [2:0] slice_ce,
   input wire [2:0] local_set_reset,
   input wire [2:0] slice_clk,
   input wire fast_carry_in,
   input wire wide_mux_in_b,
   output wire [7:0] comb_out,
   output wire [5:0] reg_out,
   output wire [3:0] wide_mux_out_low,
   output wire [3:0] wide_mux_out_high,
   output wire fast_carry_out,
   input wire [`LTS_AW-1:0] cfg_addr,
   input wire [`LTS_DW-1:0] cfg_wdata,
   input wire cfg_wr,
   input wire cfg_rd,
   output reg [`LTS_DW-1:0] cfg_rdata
);

   // mode actually in force for a slice, given variant and position
   function [1:0] lts_eff_mode;
      input [1:0] mode;
      input [1:0] slice;
      begin
         lts_eff_mode = mode;
         if (mode == `LTS_MODE_RAM && (RAM_CAPABLE == 0 ||
             slice == 2'd1 || slice == 2'd3))
            lts_eff_mode = `LTS_MODE_LOGIC; // see [R3]
         if (slice == 2'd3 && mode == `LTS_MODE_RIPPLE)
            lts_eff_mode = `LTS_MODE_LOGIC; // see [R7]
      end
   endfunction

   // one table bit picked by the four table inputs
   function lts_lookup;
      input [15:0] tbl;
      input [3:0] sel;
      begin
         lts_lookup = tbl[sel]; // see [R12] see [R21]
      end
   endfunction

   reg [15:0] tbl [0:7];
   reg [15:0] cfg [0:3];
   reg [2:0] clk_prev;
   wire [3:0] carry;
   wire [7:0] lut_f;
   wire [7:0] ram_we;
   wire [7:0] ram_di;
   wire [3:0] ram_addr;
   wire ram_wr_ev;
   wire [7:0] tbl_sel;
   wire [3:0] cfg_sel;
   integer k;

   // slice clock history, for edge detection on each slice clock
   always @(posedge clk) begin
      if (!nrst) begin
         clk_prev <= 3'h0;
      end else begin
         clk_prev <= slice_clk;
      end
   end

   // memory control comes from slice 1: clock, enable and address
   assign ram_wr_ev = slice_clk[1] & ~clk_prev[1] &
                      local_set_reset[1]; // see [R8] see [R21]
   assign ram_addr = table_in[11:8]; // see [R8]

   // configuration write decode
   assign tbl_sel = (cfg_wr && cfg_addr[4:3] == 2'b00) ?
                    (8'h01 << cfg_addr[2:0]) : 8'h00;
   assign cfg_sel = (cfg_wr && cfg_addr[4:2] == 3'b010) ?
                    (4'h1 << cfg_addr[1:0]) : 4'h0;

   // table contents: preload from the port, or written in RAM mode
   always @(posedge clk) begin
      if (!nrst) begin
         for (k = 0; k < 8; k = k + 1) begin
            tbl[k] <= `LTS_TABLE_RST;
         end
      end else begin
         for (k = 0; k < 8; k = k + 1) begin
            if (tbl_sel[k]) begin
               tbl[k] <= cfg_wdata; // see [R20]
            end else if (ram_we[k]) begin
               tbl[k][ram_addr] <= ram_di[k]; // see [R18] see [R21]
            end
         end
      end
   end

   // slice configuration words
   always @(posedge clk) begin
      if (!nrst) begin
         for (k = 0; k < 4; k = k + 1) begin
            cfg[k] <= `LTS_CFG_RST;
         end
      end else begin
         for (k = 0; k < 4; k = k + 1) begin
            if (cfg_sel[k]) begin
               cfg[k] <= cfg_wdata & `LTS_CFG_MASK;
            end
         end
      end
   end

   // read data stands only in the cycle after the read strobe
   always @(posedge clk) begin
      if (!nrst) begin
         cfg_rdata <= 16'h0000;
      end else if (cfg_rd) begin
         if (cfg_addr[4:3] == 2'b00) begin
            cfg_rdata <= tbl[cfg_addr[2:0]];
         end else if (cfg_addr[4:2] == 3'b010) begin
            cfg_rdata <= cfg[cfg_addr[1:0]];
         end else if (cfg_addr == `LTS_ADDR_STATUS) begin
            cfg_rdata <= {9'h000, fast_carry_out, reg_out};
         end else if (cfg_addr == `LTS_ADDR_INFO) begin
            cfg_rdata <= {15'h0000, RAM_CAPABLE != 0};
         end else begin
            cfg_rdata <= 16'h0000;
         end
      end else begin
         cfg_rdata <= 16'h0000;
      end
   end

   assign carry[0] = fast_carry_in; // see [R11]
   assign fast_carry_out = carry[3]; // see [R11]

   genvar s;
   generate
      for (s = 0; s < 4; s = s + 1) begin : g_slice
         localparam [1:0] SID = s;
         wire [1:0] mode;
         wire [3:0] in0;
         wire [3:0] in1;
         wire m0;
         wire m1;

         assign mode = lts_eff_mode(cfg[s][`LTS_F_MODE +: 2], SID);
         assign in0 = table_in[s*8 +: 4];
         assign in1 = table_in[s*8+4 +: 4];
         assign m0 = multi_purpose_in[2*s];
         assign m1 = multi_purpose_in[2*s+1];

         // two tables per slice, read from their own inputs
         assign lut_f[2*s] = lts_lookup(tbl[2*s], in0); // see [R2]
         assign lut_f[2*s+1] = lts_lookup(tbl[2*s+1], in1); // see [R2]

         // five-input function from the slice's two tables
         assign wide_mux_out_low[s] = m0 ? lut_f[2*s+1] :
                                      lut_f[2*s]; // see [R10] see [R12]

         // RAM writes: slice 0 takes data 1:0, slice 2 data 5:4
         assign ram_we[2*s +: 2] = {2{mode == `LTS_MODE_RAM &&
                                      ram_wr_ev}}; // see [R18]
         if (s == 2) begin : g_di2
            // companion slice mirrors slice 0 data in pseudo dual port
            assign ram_di[5:4] = cfg[2][`LTS_F_PSEUDO_DUAL_PORT_RAM] ?
                                 multi_purpose_in[1:0] :
                                 multi_purpose_in[5:4]; // see [R8] [R19]
         end else begin : g_di
            assign ram_di[2*s +: 2] = multi_purpose_in[1:0]; // see [R8]
         end

         if (s < 3) begin : g_arith
            wire [3:0] func;
            wire [1:0] a;
            wire [1:0] b;
            wire [1:0] q;
            wire cin;
            wire is_cmp;
            wire ripple;
            reg [2:0] sum;
            reg [1:0] q_r;
            reg ev;
            wire [1:0] set_val;
            wire async_lsr;
            wire preload;
            wire [1:0] d;

            assign func = cfg[s][`LTS_F_FUNC +: 4];
            assign a = {in1[0], in0[0]};
            assign b = {in1[1], in0[1]};
            assign q = q_r;
            assign cin = carry[s];
            assign ripple = (mode == `LTS_MODE_RIPPLE);
            assign is_cmp = (func == `LTS_FN_GE || func == `LTS_FN_NE ||
                             func == `LTS_FN_LE);

            // two-bit ripple arithmetic with carry in and out
            always @* begin
               case (func)
                  `LTS_FN_ADD:
                     sum = {1'b0, a} + {1'b0, b} + {2'b00, cin};
                  `LTS_FN_SUB:
                     sum = {1'b0, a} + {1'b0, ~b} + {2'b00, cin};
                  `LTS_FN_ADDSUB:
                     sum = m0 ? {1'b0, a} + {1'b0, ~b} + {2'b00, cin} :
                           {1'b0, a} + {1'b0, b} + {2'b00, cin};
                  `LTS_FN_UP:
                     sum = {1'b0, q} + {2'b00, cin}; // see [R14]
                  `LTS_FN_DOWN:
                     sum = {1'b0, q} + 3'h3 + {2'b00, cin}; // see [R14]
                  `LTS_FN_UPDN_CLR, `LTS_FN_UPDN_LOAD:
                     sum = m0 ? {1'b0, q} + 3'h3 + {2'b00, cin} :
                           {1'b0, q} + {2'b00, cin}; // see [R15]
                  `LTS_FN_GE:
                     sum = {1'b0, a} + {1'b0, ~b} + {2'b00, cin};
                  `LTS_FN_NE:
                     sum = {cin | (a != b), a ^ b}; // see [R16]
                  `LTS_FN_LE:
                     sum = {1'b0, b} + {1'b0, ~a} + {2'b00, cin};
                  `LTS_FN_MULT:
                     sum = {1'b0, a} + {1'b0, b & {2{m0}}} +
                           {2'b00, cin}; // see [R16]
                  default:
                     sum = {1'b0, a} + {1'b0, b} + {2'b00, cin};
               endcase
            end

            // carry passes through slices not in ripple mode
            assign carry[s+1] = ripple ? sum[2] : cin; // see [R17]

            // unregistered results; comparisons show the chain result
            assign comb_out[2*s +: 2] = !ripple ? lut_f[2*s +: 2] :
                                        is_cmp ? {2{sum[2]}} :
                                        sum[1:0]; // see [R9] see [R14]

            // capture event chosen by configuration
            always @* begin
               case (cfg[s][`LTS_F_EDGE +: 2])
                  `LTS_EDGE_FALL:
                     ev = ~slice_clk[s] & clk_prev[s];
                  `LTS_EDGE_LATCH:
                     ev = slice_clk[s]; // see [R5]
                  default:
                     ev = slice_clk[s] & ~clk_prev[s]; // see [R5]
               endcase
            end

            assign set_val = {cfg[s][`LTS_F_SET1], cfg[s][`LTS_F_SET0]};
            assign async_lsr = cfg[s][`LTS_F_ASYNC];
            assign preload = ripple && func == `LTS_FN_UPDN_LOAD && m1;
            assign d = preload ? b : comb_out[2*s +: 2]; // see [R15]

            // slice registers with set/reset, enable and preload
            always @(posedge clk) begin
               if (!nrst) begin
                  q_r <= `LTS_REG_RST;
               end else if (async_lsr && local_set_reset[s]) begin
                  q_r <= set_val; // see [R4] see [R15]
               end else if (ev && local_set_reset[s]) begin
                  q_r <= set_val; // see [R4] see [R22]
               end else if (ev && slice_ce[s]) begin
                  q_r <= d; // see [R22]
               end
            end

            assign reg_out[2*s +: 2] = q_r; // see [R9]
         end else begin : g_last
            // slice 3: tables only, no registers and no carry
            assign comb_out[7:6] = lut_f[7:6]; // see [R7]
         end
      end
   endgenerate

   // wider functions: six inputs in slices 1 and 3, seven in slice 2
   assign wide_mux_out_high[1] = multi_purpose_in[3] ?
      wide_mux_out_low[1] : wide_mux_out_low[0]; // see [R10] see [R13]
   assign wide_mux_out_high[3] = multi_purpose_in[7] ?
      wide_mux_out_low[3] : wide_mux_out_low[2]; // see [R10] see [R13]
   assign wide_mux_out_high[2] = multi_purpose_in[5] ?
      wide_mux_out_high[3] : wide_mux_out_high[1]; // see [R13]
   // eight inputs: this tile's seven-input half against a neighbour's
   assign wide_mux_out_high[0] = multi_purpose_in[1] ?
      wide_mux_in_b : wide_mux_out_high[2]; // see [R10] see [R13]

   // port count: 40 table/mux inputs, 9 controls, carry-in; 23 outputs
   // see [R1] see [R6]

endmodule // lts_logic_tile

`default_nettype wire

// >>> lts_defines.vh
`ifndef LTS_DEFINES_VH
`define LTS_DEFINES_VH

// configuration port width
`define LTS_AW 5
`define LTS_DW 16

// configuration port word addresses
`define LTS_ADDR_TABLE 5'h00
`define LTS_ADDR_CFG 5'h08
`define LTS_ADDR_STATUS 5'h0C
`define LTS_ADDR_INFO 5'h0D

// slice configuration word fields (low bit positions)
`define LTS_F_MODE 0
`define LTS_F_FUNC 2
`define LTS_F_EDGE 6
`define LTS_F_ASYNC 8
`define LTS_F_SET0 9
`define LTS_F_SET1 10
`define LTS_F_PSEUDO_DUAL_PORT_RAM 11
`define LTS_CFG_MASK 16'h0FFF

// reset values
`define LTS_CFG_RST 16'h0000
`define LTS_TABLE_RST 16'h0000
`define LTS_REG_RST 2'h0

// slice modes
`define LTS_MODE_LOGIC 2'h0
`define LTS_MODE_RIPPLE 2'h1
`define LTS_MODE_RAM 2'h2
`define LTS_MODE_ROM 2'h3

// ripple functions
`define LTS_FN_ADD 4'h0
`define LTS_FN_SUB 4'h1
`define LTS_FN_ADDSUB 4'h2
`define LTS_FN_UP 4'h3
`define LTS_FN_DOWN 4'h4
`define LTS_FN_UPDN_CLR 4'h5
`define LTS_FN_UPDN_LOAD 4'h6
`define LTS_FN_GE 4'h7
`define LTS_FN_NE 4'h8
`define LTS_FN_LE 4'h9
`define LTS_FN_MULT 4'hA

// register capture style
`define LTS_EDGE_RISE 2'h0
`define LTS_EDGE_FALL 2'h1
`define LTS_EDGE_LATCH 2'h2

`endif

// >>> lts_fabric.sv
`timescale 1ns/1ps
`default_nettype none
// fabric model: drives slice clock pulses, held one to four cycles
module lts_fabric (
   input wire logic clk,
   input wire logic [2:0] req,
   input wire logic [1:0] hold,
   output logic [2:0] slice_clk
);
   logic [2:0] sel = 3'h0;
   logic [2:0] cnt = 3'h0;
   // a request starts a pulse; the clock stands low between pulses
   always @(posedge clk) begin
      if (req != 3'h0) begin
         sel <= req;
         cnt <= {1'b0, hold} + 3'h1;
      end else if (cnt != 3'h0) begin
         cnt <= cnt - 3'h1;
      end
   end
   assign slice_clk = (cnt != 3'h0) ? sel : 3'h0;
endmodule // lts_fabric
`default_nettype wire

// >>> lts_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "lts_defines.vh"
// port checker for the tile
module lts_chk #(
   parameter RAM_CAPABLE = 1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [2:0] slice_ce,
   input wire logic [2:0] local_set_reset,
   input wire logic [2:0] slice_clk,
   input wire logic [7:0] comb_out,
   input wire logic [5:0] reg_out,
   input wire logic fast_carry_out,
   input wire logic [4:0] cfg_addr,
   input wire logic cfg_rd,
   input wire logic [15:0] cfg_rdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // slice clock events as seen on the system clock
   sequence rise0;
      $rose(slice_clk[0]);
   endsequence
   sequence quiet1;
      !slice_clk[1] && !$past(slice_clk[1]);
   endsequence
   idle_rdata_a: assert property (!cfg_rd |=> cfg_rdata == '0)
      else $error("read data outside read slot");
   unmapped_read_a: assert property (
      cfg_rd && cfg_addr > 5'h0d |=> cfg_rdata == '0)
      else $error("unmapped read not zero");
   info_read_a: assert property (
      cfg_rd && cfg_addr == `LTS_ADDR_INFO |=> cfg_rdata == 16'(RAM_CAPABLE))
      else $error("variant bit wrong");
   status_read_a: assert property (
      cfg_rd && cfg_addr == `LTS_ADDR_STATUS |=>
      cfg_rdata == {9'h000, $past(fast_carry_out), $past(reg_out)})
      else $error("status word wrong");
   reset_clear_a: assert property (@(posedge clk) disable iff (1'b0)
      !nrst |=> reg_out == '0 && cfg_rdata == '0)
      else $error("reset did not clear");
   hold_ce_a: assert property (
      !slice_ce[0] && !local_set_reset[0] |=> $stable(reg_out[1:0]))
      else $error("register moved without enable");
   capture_rise_a: assert property (
      rise0 ##0 (slice_ce[0] && !local_set_reset[0]) |=>
      reg_out[1:0] == $past(comb_out[1:0]))
      else $error("register missed table result");
   quiet_hold_a: assert property (
      quiet1 ##0 !local_set_reset[1] |=> $stable(reg_out[3:2]))
      else $error("register moved without clock event");
   sync_set_a: assert property (
      rise0 ##0 local_set_reset[0] |=> reg_out[1:0] == 2'h0)
      else $error("set/reset value not applied");
endmodule // lts_chk
bind lts_logic_tile lts_chk #(.RAM_CAPABLE(RAM_CAPABLE)) lts_chk_inst (
   .clk(clk), .nrst(nrst), .slice_ce(slice_ce),
   .local_set_reset(local_set_reset), .slice_clk(slice_clk),
   .comb_out(comb_out), .reg_out(reg_out), .fast_carry_out(fast_carry_out),
   .cfg_addr(cfg_addr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata)
);
`default_nettype wire

// >>> test_logic_tile_slices.sv
`timescale 1ns/1ps
`default_nettype none
`include "lts_defines.vh"
// tile bench: register port, logic, ripple, slice registers and ram
module test_logic_tile_slices;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [31:0] table_in = 32'h0000_0000;
   logic [7:0] multi_purpose_in = 8'h00;
   logic [2:0] slice_ce = 3'h0;
   logic [2:0] local_set_reset = 3'h0;
   logic fast_carry_in = 1'b0;
   logic wide_mux_in_b = 1'b0;
   logic [4:0] cfg_addr = 5'h00;
   logic [15:0] cfg_wdata = 16'h0000;
   logic cfg_wr = 1'b0;
   logic cfg_rd = 1'b0;
   logic [2:0] req = 3'h0;
   logic [1:0] hold = 2'h0;
   logic [31:0] rnd = 32'hf8e8_d2f9;
   logic [15:0] v0, v1;
   logic [3:0] fns [4];
   logic [1:0] q = 2'h0;
   logic [2:0] e;
   int fails = 0;
   int compares = 0;
   wire [2:0] slice_clk;
   wire [7:0] comb_out;
   wire [5:0] reg_out;
   wire fast_carry_out;
   wire [15:0] cfg_rdata;
   wire [3:0] wm_low;
   wire [3:0] wm_high;

   lts_logic_tile #(.RAM_CAPABLE(1)) lts_logic_tile_inst (
      .clk(clk), .nrst(nrst), .table_in(table_in),
      .multi_purpose_in(multi_purpose_in), .slice_ce(slice_ce),
      .local_set_reset(local_set_reset), .slice_clk(slice_clk),
      .fast_carry_in(fast_carry_in), .wide_mux_in_b(wide_mux_in_b),
      .comb_out(comb_out), .reg_out(reg_out), .wide_mux_out_low(wm_low),
      .wide_mux_out_high(wm_high), .fast_carry_out(fast_carry_out),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr),
      .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata)
   );
   lts_fabric lts_fabric_inst (
      .clk(clk), .req(req), .hold(hold), .slice_clk(slice_clk)
   );

   initial forever #25 clk = ~clk;

   function automatic [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // expected {carry, result} of one ripple slice
   function automatic [2:0] ripple(input [3:0] fn, input [1:0] a, b,
                                   input ci);
      logic [2:0] d, c;
      d = {1'b0, a} + {1'b0, ~b} + {2'h0, ci};
      c = {1'b0, b} + {1'b0, ~a} + 3'h1;
      case (fn)
         `LTS_FN_ADD: ripple = {1'b0, a} + {1'b0, b} + {2'h0, ci};
         `LTS_FN_SUB: ripple = d;
         `LTS_FN_GE: ripple = {3{d[2]}};
         default: ripple = {3{c[2]}};
      endcase
   endfunction
   task automatic chk(input [15:0] got, exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input [4:0] a, input [15:0] d);
      @(posedge clk);
      cfg_addr <= a;
      cfg_wdata <= d;
      cfg_wr <= 1'b1;
      @(posedge clk);
      cfg_wr <= 1'b0;
   endtask
   task automatic rd(input [4:0] a, input [15:0] exp);
      @(posedge clk);
      cfg_addr <= a;
      cfg_rd <= 1'b1;
      @(posedge clk);
      cfg_rd <= 1'b0;
      @(negedge clk);
      chk(cfg_rdata, exp);
   endtask
   // one slice clock pulse from the fabric model, prompt or slow
   task automatic pulse(input [2:0] m);
      @(posedge clk);
      req <= m;
      hold <= rnd[1:0];
      @(posedge clk);
      req <= 3'h0;
      repeat (7) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic conclude();
      $display("fails=%0d compares=%0d", fails, compares);
      if (fails == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      #2_000_000;
      fails++;
      conclude();
   end

   // main sequence
   initial begin
      fns = '{`LTS_FN_ADD, `LTS_FN_SUB, `LTS_FN_GE, `LTS_FN_LE};
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      for (int k = 0; k < 13; k++) rd(5'(k), 16'h0000);
      wr(`LTS_ADDR_INFO, 16'h0000);
      rd(`LTS_ADDR_INFO, 16'h0001);
      wr(5'h1f, 16'hffff);
      rd(5'h1f, 16'h0000);
      wr(`LTS_ADDR_CFG + 5'h3, 16'hffff);
      rd(`LTS_ADDR_CFG + 5'h3, `LTS_CFG_MASK);
      // logic mode: every input combination of both tables
      v0 = rnd[15:0];
      v1 = rnd[31:16];
      wr(`LTS_ADDR_TABLE, v0);
      wr(`LTS_ADDR_TABLE + 5'h1, v1);
      rd(`LTS_ADDR_TABLE, v0);
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         table_in <= {rnd[31:8], 4'(15 - i), 4'(i)};
         multi_purpose_in <= {7'h00, i[0]};
         @(negedge clk);
         chk({14'h0, comb_out[1:0]}, {14'h0, v1[15 - i], v0[i]});
         // five-input mux, passed through to the eight-input output
         e[0] = i[0] ? v1[15 - i] : v0[i];
         chk({14'h0, wm_high[0], wm_low[0]}, {14'h0, {2{e[0]}}});
      end
      // slice 0 registers: capture, hold without enable, set
      for (int n = 0; n < 6; n++) begin
         rnd = lfsr(rnd);
         @(posedge clk);
         table_in <= rnd;
         slice_ce[0] <= n[0];
         local_set_reset[0] <= (n == 5);
         pulse(3'h1);
         if (n == 5) q = 2'h0;
         else if (n[0]) q = {v1[rnd[7:4]], v0[rnd[3:0]]};
         chk({14'h0, reg_out[1:0]}, {14'h0, q});
      end
      // slice 2 asynchronous set to configured ones, no clock event
      wr(`LTS_ADDR_CFG + 5'h2, 16'h0700);
      @(posedge clk);
      local_set_reset[2] <= 1'b1;
      repeat (3) @(posedge clk);
      local_set_reset[2] <= 1'b0;
      @(negedge clk);
      chk({14'h0, reg_out[5:4]}, 16'h0003);
      // ripple functions on slice 0, carry through slices 1 and 2
      foreach (fns[f]) begin
         wr(`LTS_ADDR_CFG, {10'h000, fns[f], 2'h1});
         for (int n = 0; n < 8; n++) begin
            rnd = lfsr(rnd);
            @(posedge clk);
            table_in <= rnd;
            fast_carry_in <= (f > 1) | rnd[9];
            wide_mux_in_b <= rnd[10];
            @(negedge clk);
            e = ripple(fns[f], {table_in[4], table_in[0]},
                       {table_in[5], table_in[1]}, fast_carry_in);
            chk({13'h0, fast_carry_out, comb_out[1:0]},
                {13'h0, e});
         end
      end
      // slice 0 as ram, written under slice 1 control
      wr(`LTS_ADDR_CFG, 16'h0002);
      for (int n = 0; n < 6; n++) begin
         rnd = lfsr(rnd);
         @(posedge clk);
         table_in <= {20'h0_0000, {3{rnd[3:0]}}};
         multi_purpose_in <= {6'h00, rnd[5:4]};
         local_set_reset[1] <= (n != 3);
         pulse(3'h2);
         if (n != 3) {v1[rnd[3:0]], v0[rnd[3:0]]} = rnd[5:4];
         chk({14'h0, comb_out[1:0]},
             {14'h0, v1[rnd[3:0]], v0[rnd[3:0]]});
      end
      rd(`LTS_ADDR_TABLE, v0);
      rd(`LTS_ADDR_STATUS, {9'h000, fast_carry_in, 4'hc, q});
      conclude();
   end
endmodule // test_logic_tile_slices
`default_nettype wire
